// File: hdl/msm_consts.svh
// Constants of the memory segment mapper.
// Notes on behaviour
// RQ1 - One shared 64 Kbyte RAM serves code, internal data and external data.
// RQ2 - Software may reprogram code and external bases and sizes, and data base.
// RQ3 - A 4 Kbyte boot ROM holds the bootstrap and programming loader.
// RQ4 - Boot ROM sits at physical 10000h and answers logical code 0000h after reset.
// RQ5 - Internal data 00h-7Fh reaches lower RAM, direct or indirect.
// RQ6 - Lowest 32 bytes form four banks of eight working registers.
// RQ7 - Two bank-select bits pick bank at 00h, 08h, 10h or 18h.
// RQ8 - Sixteen bytes above banks hold 128 bits, bit addresses 00h-7Fh.
// RQ9 - Internal data 80h-FFh reaches upper RAM only when indirect.
// RQ10 - Direct access in 80h-FFh goes to special function registers.
// RQ11 - Expanded RAM is reached only by external-move indirect accesses.
// RQ12 - Separate registers hold code, data, external bases and code, external sizes.
// RQ13 - Internal data segment is a fixed 256 bytes with no size setting.
// RQ14 - Code and external bases hold bits 16:9, 512-byte aligned, no offset.
// RQ15 - Data base holds bits 16:9 plus a fixed 256-byte offset.
// RQ16 - Code size is (value plus one) times 256 bytes.
// RQ17 - Reset: data base 0 1111 111b, external base 0 1111 000b.
// RQ18 - Physical address is segment base plus logical offset, 17 bits wide.
`ifndef MSM_CONSTS_SVH
`define MSM_CONSTS_SVH
`define MSM_REG_CODE_BASE 8'hf2
`define MSM_REG_DATA_BASE 8'hf3
`define MSM_REG_EXT_BASE 8'hf4
`define MSM_REG_CODE_SIZE 8'hf5
`define MSM_REG_EXT_SIZE 8'hf6
`define MSM_REG_STATUS 8'hf7
`define MSM_RST_CODE_BASE 8'h00
`define MSM_RST_DATA_BASE 8'h7f
`define MSM_RST_EXT_BASE 8'h78
`define MSM_RST_CODE_SIZE 8'hef
`define MSM_RST_EXT_SIZE 8'hff
`define MSM_BOOT_BASE 17'h10000
`define MSM_BOOT_LAST 16'h0fff
`define MSM_DATA_OFFSET 17'h00100
`define MSM_BANK_SHIFT 3
`define MSM_BIT_AREA 8'h20
`define MSM_UPPER 8'h80
`endif

// File: hdl/msm_mapper.sv
// Memory segment mapper: logical to physical translation and segment registers.
`timescale 1ns/1ps
`include "msm_consts.svh"
module msm_mapper (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic srst,
    // Core access request and bank select bits of the program status word.
    input wire msm_pkg::msm_req_t req,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Mapped access.
    output msm_pkg::msm_map_t map
);
    import msm_pkg::*;

    logic [7:0] code_base_register;
    logic [7:0] data_base_register;
    logic [7:0] ext_data_base_register;
    logic [7:0] code_size_register;
    logic [7:0] ext_data_size_register;
    logic boot_mapped;
    msm_map_t next_map;

    function automatic logic [16:0] base_of(input logic [7:0] field);
        base_of = {field, 9'h000};
    endfunction

    function automatic logic in_size(input logic [15:0] off, input logic [7:0] size);
        in_size = off[15:8] <= size;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Segment registers.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            code_base_register <= `MSM_RST_CODE_BASE;
            data_base_register <= `MSM_RST_DATA_BASE; // [RQ17]
            ext_data_base_register <= `MSM_RST_EXT_BASE; // [RQ17]
            code_size_register <= `MSM_RST_CODE_SIZE;
            ext_data_size_register <= `MSM_RST_EXT_SIZE;
        end else if (reg_wr) begin
            unique case (reg_addr) // [RQ2] [RQ12]
                `MSM_REG_CODE_BASE: code_base_register <= reg_wdata;
                `MSM_REG_DATA_BASE: data_base_register <= reg_wdata;
                `MSM_REG_EXT_BASE: ext_data_base_register <= reg_wdata;
                `MSM_REG_CODE_SIZE: code_size_register <= reg_wdata;
                `MSM_REG_EXT_SIZE: ext_data_size_register <= reg_wdata;
                default: ;
            endcase
        end
    end

    // The boot ROM owns logical code 0 until software first writes the code base,
    // so the bootstrap runs after reset without any setup.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            boot_mapped <= 1'b1; // [RQ4]
        end else if (reg_wr && reg_addr == `MSM_REG_CODE_BASE) begin
            boot_mapped <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `MSM_REG_CODE_BASE: reg_rdata <= code_base_register;
                `MSM_REG_DATA_BASE: reg_rdata <= data_base_register;
                `MSM_REG_EXT_BASE: reg_rdata <= ext_data_base_register;
                `MSM_REG_CODE_SIZE: reg_rdata <= code_size_register;
                `MSM_REG_EXT_SIZE: reg_rdata <= ext_data_size_register;
                `MSM_REG_STATUS: reg_rdata <= {7'h00, boot_mapped};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address translation.
    always_comb begin
        logic [7:0] daddr;
        daddr = req.addr[7:0];
        next_map = '0;
        next_map.valid = req.valid;
        unique case (req.space)
            msm_code: begin
                if (boot_mapped && req.addr <= `MSM_BOOT_LAST) begin
                    next_map.to_rom = 1'b1; // [RQ3] [RQ4]
                    next_map.phys = `MSM_BOOT_BASE + {5'h00, req.addr[11:0]};
                end else begin
                    // [RQ14] [RQ16] [RQ18] [RQ1]
                    next_map.phys = base_of(code_base_register) + {1'b0, req.addr};
                    next_map.out_of_seg = !in_size(req.addr, code_size_register);
                end
            end
            msm_ext: begin
                // Without an indirect external move the request is not an expanded RAM cycle.
                next_map.valid = req.valid && req.indirect; // [RQ11]
                next_map.phys = base_of(ext_data_base_register) + {1'b0, req.addr}; // [RQ18]
                next_map.out_of_seg = !in_size(req.addr, ext_data_size_register);
            end
            msm_bit: begin
                // [RQ8] Bits 00h-7Fh live in bytes 20h-2Fh.
                daddr = `MSM_BIT_AREA + {4'h0, req.addr[6:3]};
                next_map.bit_pos = req.addr[2:0];
                next_map.phys = base_of(data_base_register) + `MSM_DATA_OFFSET
                    + {9'h000, daddr}; // [RQ15]
                next_map.to_sfr = req.addr[7]; // [RQ10]
            end
            msm_data: begin
                if (req.reg_ref) begin
                    // [RQ6] [RQ7]
                    daddr = {3'b000, bank_select_high, bank_select_low, req.reg_num};
                end
                // [RQ5] [RQ9] [RQ10] Upper half is RAM only for indirect accesses.
                next_map.to_sfr = daddr >= `MSM_UPPER && !req.indirect && !req.reg_ref;
                // [RQ13] [RQ15] [RQ18] Only eight offset bits: fixed 256 bytes.
                next_map.phys = base_of(data_base_register) + `MSM_DATA_OFFSET
                    + {9'h000, daddr};
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            map <= '0;
        end else begin
            map <= next_map;
        end
    end
endmodule

// File: hdl/msm_pkg.sv
// Types of the memory segment mapper.
package msm_pkg;
    typedef enum logic [1:0] {
        msm_code,
        msm_data,
        msm_ext,
        msm_bit
    } msm_space_t;
    typedef struct packed {
        logic valid;
        msm_space_t space;
        logic indirect;
        logic reg_ref;
        logic [2:0] reg_num;
        logic [15:0] addr;
    } msm_req_t;
    typedef struct packed {
        logic valid;
        logic to_rom;
        logic to_sfr;
        logic out_of_seg;
        logic [16:0] phys;
        logic [2:0] bit_pos;
    } msm_map_t;
endpackage

// File: tb/msm_core_model.sv
// Processor core model that issues memory requests to the mapper.
`timescale 1ns/1ps
module msm_core_model (
    // Clock in, request and bank bits out.
    input wire logic ref_clk,
    output msm_pkg::msm_req_t req = '0,
    output logic bank_select_low = 1'b0,
    output logic bank_select_high = 1'b0
);
    import msm_pkg::*;
    // After one cycle valid drops and the other request fields are inverted, so stale values cannot pass for fresh ones.
    task automatic issue(input msm_req_t r, input logic [1:0] bank);
        @(posedge ref_clk);
        {req, bank_select_high, bank_select_low} <= {r, bank};
        @(posedge ref_clk);
        req <= {1'b0, ~r[$bits(msm_req_t)-2:0]};
    endtask
endmodule

// File: tb/msm_mapper_assertions.sv
// Port assertions for the memory segment mapper.
`timescale 1ns/1ps
module msm_mapper_assertions (
    // Watched ports.
    input wire logic ref_clk,
    input wire logic srst,
    input wire msm_pkg::msm_req_t req,
    input wire logic bank_select_low,
    input wire logic bank_select_high,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire msm_pkg::msm_map_t map
);
    import msm_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire logic dat = req.valid && req.space == msm_data;
    wire logic [4:0] rsel = {bank_select_high, bank_select_low, req.reg_num};
    sequence no_read; !reg_rd; endsequence
    rom_fetch_a: assert property (
        map.to_rom |-> map.phys == {5'h10, $past(req.addr[11:0])}) else $error("rom");
    sfr_direct_a: assert property (
        dat && !req.indirect && !req.reg_ref && req.addr[7] |=> map.to_sfr) else $error("sfr");
    indirect_ram_a: assert property (
        dat && req.indirect && !req.reg_ref |=> !map.to_sfr) else $error("indirect");
    lower_data_a: assert property (
        dat && !req.addr[7] && !req.reg_ref |=> !map.to_sfr && map.phys[8]) else $error("lower");
    bank_reg_a: assert property (
        dat && req.reg_ref |=> map.phys[7:0] == {3'h0, $past(rsel)}) else $error("bank");
    bit_area_a: assert property (
        req.valid && req.space == msm_bit |=> map.bit_pos == $past(req.addr[2:0])) else $error("bit");
    ext_direct_a: assert property (
        req.valid && req.space == msm_ext && !req.indirect |=> !map.valid) else $error("ext");
    read_idle_a: assert property (no_read |=> reg_rdata == 8'h00) else $error("rdata");
endmodule
bind msm_mapper msm_mapper_assertions u_chk (.*);

// File: tb/tb_msm_mapper.sv
// Self-checking testbench of the memory segment mapper.
`timescale 1ns/1ps
module tb_msm_mapper;
    import msm_pkg::*;
    logic ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic bank_select_low, bank_select_high;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    msm_req_t req;
    msm_map_t map;
    int num_errors = 0, samples_checked = 0;
    always #12.5 ref_clk = ~ref_clk;
    msm_core_model core (.*);
    msm_mapper DUT (.*);
    task automatic finish_test(input logic hang);
        num_errors += int'(hang);
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic tally(input logic ok);
        samples_checked++;
        num_errors += int'(ok !== 1'b1);
        if (ok !== 1'b1) $display("CHECK FAILED at %0t: unexpected value", $time);
    endtask
    // Writes when w is set, otherwise reads and compares with d.
    task automatic reg_op(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, !w};
        @(posedge ref_clk);
        {reg_wr, reg_rd} <= 2'b00;
        #1 if (!w) tally(reg_rdata === d);
    endtask
    // f holds bank bits, indirect, register reference and number; all-ones e expects no map.
    task automatic acc(input msm_space_t s, input logic [6:0] f, input logic [15:0] a,
        input logic [22:0] e);
        core.issue({1'b1, s, f[4:0], a}, f[6:5]);
        #1 tally(&e ? map.valid === 1'b0 : map === {1'b1, e});
    endtask
    initial #50us finish_test(1'b1);
    initial begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        reg_op(1'b0, 8'hf3, 8'h7f);
        reg_op(1'b0, 8'hf4, 8'h78);
        reg_op(1'b0, 8'hf7, 8'h01);
        acc(msm_code, 7'h00, 16'h0fff, {3'b100, 17'h10fff, 3'h0});
        acc(msm_code, 7'h00, 16'hf000, {3'b001, 17'h0f000, 3'h0});
        for (int b = 0; b < 4; b++)
            acc(msm_data, {b[1:0], 5'h0b}, 16'h0000,
                {3'b000, 9'h0ff, 3'h0, b[1:0], 3'h3, 3'h0});
        acc(msm_bit, 7'h00, 16'h007f, {3'b000, 17'h0ff2f, 3'h7});
        acc(msm_data, 7'h00, 16'h0080, {3'b010, 17'h0ff80, 3'h0});
        acc(msm_data, 7'h10, 16'h00ff, {3'b000, 17'h0ffff, 3'h0});
        acc(msm_ext, 7'h00, 16'h0010, '1);
        acc(msm_ext, 7'h10, 16'h0010, {3'b000, 17'h0f010, 3'h0});
        reg_op(1'b1, 8'hf2, 8'h01);
        acc(msm_code, 7'h00, 16'h0100, {3'b000, 17'h00300, 3'h0});
        $display("mapping tests done");
        finish_test(1'b0);
    end
endmodule
